// ==== logic/cvsc_core.sv ====
// Purpose: register file and dynamic core voltage ramp of the power manager
// Assumes: serial interface engine outside delivers one-cycle register requests
// Notes: resetn is the undervoltage lockout reset
//
// Function
// R1 - phase/mode bit 1 forces system converter into fixed-frequency PWM.
// R2 - phase/mode bit 0 forces core converter into fixed-frequency PWM.
// R3 - start bit ramps core code toward target at selected slew rate.
// R4 - start bit low keeps core code unchanged despite target rewrites.
// R5 - start bit self-clears when internal code equals target code.
// R6 - bit 6 chooses strap pin or register as core voltage source.
// R7 - strap low starts core at 1.3 V, strap high at 1.55 V.
// R8 - bits 2..0 enable active discharge for memory, system, core converters.
// R9 - control register resets to 40h; start bit also clears on completion.
// R10 - core code maps 0.8 V plus 25 mV steps; code 31 gives 1.6 V.
// R11 - core code default 14h or 1Eh; bits 3 and 1 follow strap.
// R12 - core code reloads on lockout, both converters off, warm reset, POR, RTC low.
// R13 - slew code 0..6 doubles from 0.15 mV/us; 7 is immediate; resets 06h.
// R14 - linear regulator fields select 1..3.3 V from eight values.
// R15 - core rail not-good reads 0 during a transition or when disabled.
// R16 - ramp steps one code at a time, interval 25 mV over slew rate.
// R17 - software sets target and slew first, then polls start bit clear.
`timescale 1ns/1ps
`include "cvsc_map.svh"
module cvsc_core #(
   parameter int SLOW_STEP_CYCLES = int'(`CVSC_SLOW_STEP_CYCLES)
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input cvsc_pkg::cvsc_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic core_strap_pin,
   input wire logic system_converter_enabled,
   input wire logic core_converter_enabled,
   input wire logic warm_reset_pin_n,
   input wire logic power_on_reset_out,
   input wire logic rtc_supply_low,
   input wire logic core_rail_below_target,
   output logic forced_fixed_freq_mem,
   output logic forced_fixed_freq_sys,
   output logic forced_fixed_freq_core,
   output logic [2:0] discharge_en,
   output logic core_ref_from_strap,
   output logic [4:0] core_code,
   output logic ramp_busy,
   output logic core_rail_not_good,
   output cvsc_pkg::cvsc_levels_t levels
);
   logic [7:0] phase_mode_control;
   logic [7:0] dvm_converter_control;
   logic [4:0] core_target_code;
   logic [2:0] core_ramp_select;
   logic [7:0] linear_reg_voltage;
   logic strap_loaded;
   logic [7:0] next_phase_mode_control;
   logic [7:0] next_dvm_converter_control;
   logic [4:0] next_core_target_code;
   logic [2:0] next_core_ramp_select;
   logic [7:0] next_linear_reg_voltage;
   logic [7:0] next_reg_rdata;

   cvsc_pkg::cvsc_state_t state;
   cvsc_pkg::cvsc_state_t next_state;
   logic [4:0] next_core_code;
   logic next_core_rail_not_good;

   logic reload_code;
   logic start_bit;
   logic done;
   logic tick;
   logic [4:0] strap_code;

   function automatic logic wr_hit(input cvsc_pkg::cvsc_reg_req_t r, input logic [7:0] a);
      return r.wr_en && (r.addr == a);
   endfunction : wr_hit

   function automatic logic [4:0] step_toward(input logic [4:0] cur, input logic [4:0] tgt);
      if (cur < tgt) begin
         return cur + 5'h01;
      end else if (cur > tgt) begin
         return cur - 5'h01;
      end
      return cur;
   endfunction : step_toward

   assign start_bit = dvm_converter_control[`CVSC_BIT_START];
   // strap drives bits 3 and 1 of the default
   assign strap_code = `CVSC_RST_CORE_CODE | {1'b0, core_strap_pin, 1'b0, core_strap_pin, 1'b0}; // R11 R7
   // first clock after release catches the strap
   assign reload_code = !strap_loaded || (!system_converter_enabled && !core_converter_enabled) ||
                        !warm_reset_pin_n || power_on_reset_out || rtc_supply_low; // R12
   // internal code has met target while a ramp runs
   assign done = (state == cvsc_pkg::CVSC_RAMP) && (core_code == core_target_code); // R5

   // register group
   always_comb begin
      next_phase_mode_control = phase_mode_control;
      next_dvm_converter_control = dvm_converter_control;
      next_core_target_code = core_target_code;
      next_core_ramp_select = core_ramp_select;
      next_linear_reg_voltage = linear_reg_voltage;
      next_reg_rdata = reg_rdata;
      // completion clears start; a same-cycle write of 1 below wins
      if (done) begin
         next_dvm_converter_control[`CVSC_BIT_START] = 1'b0; // R5 R9
      end
      if (wr_hit(reg_req, `CVSC_ADDR_PHASE_MODE)) begin
         next_phase_mode_control = reg_req.wdata;
      end
      if (wr_hit(reg_req, `CVSC_ADDR_DVM_CTRL)) begin
         next_dvm_converter_control = reg_req.wdata & 8'hC7; // R9
      end
      if (wr_hit(reg_req, `CVSC_ADDR_CORE_CODE)) begin
         next_core_target_code = reg_req.wdata[4:0];
      end
      if (wr_hit(reg_req, `CVSC_ADDR_RAMP_SEL)) begin
         next_core_ramp_select = reg_req.wdata[2:0]; // R13
      end
      if (wr_hit(reg_req, `CVSC_ADDR_LINEAR)) begin
         next_linear_reg_voltage = reg_req.wdata & 8'h77;
      end
      if (reload_code) begin
         next_core_target_code = strap_code; // R12
      end
      if (reg_req.rd_en) begin
         case (reg_req.addr)
            `CVSC_ADDR_PHASE_MODE: next_reg_rdata = phase_mode_control;
            `CVSC_ADDR_DVM_CTRL: next_reg_rdata = dvm_converter_control;
            `CVSC_ADDR_CORE_CODE: next_reg_rdata = {3'h0, core_target_code};
            `CVSC_ADDR_RAMP_SEL: next_reg_rdata = {5'h00, core_ramp_select};
            `CVSC_ADDR_LINEAR: next_reg_rdata = linear_reg_voltage;
            default: next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase_mode_control <= `CVSC_RST_PHASE_MODE;
         dvm_converter_control <= `CVSC_RST_DVM_CTRL; // R9
         core_target_code <= `CVSC_RST_CORE_CODE;
         core_ramp_select <= `CVSC_RST_RAMP_SEL; // R13
         linear_reg_voltage <= `CVSC_RST_LINEAR;
         reg_rdata <= 8'h00;
         strap_loaded <= 1'b0;
      end else begin
         phase_mode_control <= next_phase_mode_control;
         dvm_converter_control <= next_dvm_converter_control;
         core_target_code <= next_core_target_code;
         core_ramp_select <= next_core_ramp_select;
         linear_reg_voltage <= next_linear_reg_voltage;
         reg_rdata <= next_reg_rdata;
         strap_loaded <= 1'b1;
      end
   end

   // ramp group
   always_comb begin
      next_state = state;
      next_core_code = core_code;
      case (state)
         cvsc_pkg::CVSC_IDLE: begin
            // code held while start is low
            if (start_bit) begin
               next_state = cvsc_pkg::CVSC_RAMP; // R3 R4
            end
         end
         cvsc_pkg::CVSC_RAMP: begin
            if (done) begin
               next_state = cvsc_pkg::CVSC_DONE; // R5
            end else if (core_ramp_select == `CVSC_RAMP_IMMEDIATE) begin
               next_core_code = core_target_code; // R13
            end else if (tick) begin
               next_core_code = step_toward(core_code, core_target_code); // R3 R16
            end
         end
         cvsc_pkg::CVSC_DONE: begin
            next_state = cvsc_pkg::CVSC_IDLE;
         end
         default: begin
            next_state = cvsc_pkg::CVSC_IDLE;
         end
      endcase
      if (reload_code) begin
         next_state = cvsc_pkg::CVSC_IDLE;
         next_core_code = strap_code; // R12 R7
      end
      next_core_rail_not_good = core_rail_below_target && core_converter_enabled &&
                                (state == cvsc_pkg::CVSC_IDLE) && !start_bit; // R15
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= cvsc_pkg::CVSC_IDLE;
         core_code <= `CVSC_RST_CORE_CODE;
         core_rail_not_good <= 1'b0;
      end else begin
         state <= next_state;
         core_code <= next_core_code;
         core_rail_not_good <= next_core_rail_not_good;
      end
   end

   assign ramp_busy = (state != cvsc_pkg::CVSC_IDLE) || start_bit;
   assign forced_fixed_freq_sys = phase_mode_control[`CVSC_BIT_FFF_SYS]; // R1
   assign forced_fixed_freq_core = phase_mode_control[`CVSC_BIT_FFF_CORE]; // R2
   assign forced_fixed_freq_mem = phase_mode_control[`CVSC_BIT_FFF_MEM];
   assign discharge_en = {dvm_converter_control[`CVSC_BIT_DIS_MEM], dvm_converter_control[`CVSC_BIT_DIS_SYS],
                          dvm_converter_control[`CVSC_BIT_DIS_CORE]}; // R8
   assign core_ref_from_strap = dvm_converter_control[`CVSC_BIT_STRAP_SRC]; // R6

   cvsc_ramp_timer #(
      .SLOW_STEP_CYCLES(SLOW_STEP_CYCLES),
      .CW(16)
   ) u_timer (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .run(state == cvsc_pkg::CVSC_RAMP),
      .ramp_sel(core_ramp_select),
      .tick(tick)
   );

   cvsc_code_decode u_decode (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .core_code(core_code),
      .linear_one_sel(linear_reg_voltage[2:0]),
      .linear_two_sel(linear_reg_voltage[6:4]),
      .levels(levels)
   );
endmodule : cvsc_core

// ==== logic/cvsc_map.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the core scaling control
// Assumes: 8-bit register port, 200 MHz ref_clk
// Notes: definitions only
`ifndef CVSC_MAP_SVH
`define CVSC_MAP_SVH

`define CVSC_ADDR_PHASE_MODE 8'h04
`define CVSC_ADDR_DVM_CTRL 8'h05
`define CVSC_ADDR_CORE_CODE 8'h06
`define CVSC_ADDR_RAMP_SEL 8'h07
`define CVSC_ADDR_LINEAR 8'h08

`define CVSC_RST_PHASE_MODE 8'hB0
`define CVSC_RST_DVM_CTRL 8'h40
`define CVSC_RST_CORE_CODE 5'h14
`define CVSC_RST_RAMP_SEL 3'h6
`define CVSC_RST_LINEAR 8'h23

`define CVSC_BIT_START 7
`define CVSC_BIT_STRAP_SRC 6
`define CVSC_BIT_DIS_MEM 2
`define CVSC_BIT_DIS_SYS 1
`define CVSC_BIT_DIS_CORE 0
`define CVSC_BIT_FFF_MEM 2
`define CVSC_BIT_FFF_SYS 1
`define CVSC_BIT_FFF_CORE 0

`define CVSC_RAMP_IMMEDIATE 3'h7
`define CVSC_CORE_BASE_MV 11'h320
`define CVSC_CORE_STEP_MV 11'h019
`define CVSC_CORE_TOP_MV 11'h640

// one code step is 25 mV; slowest ramp is 150 uV/us
`define CVSC_STEP_UV 64'd25000
`define CVSC_SLOW_RATE_UV_PER_US 64'd150
`define CVSC_CLK_PERIOD_PS 64'd5000
`define CVSC_SLOW_STEP_PS (`CVSC_STEP_UV * 64'd1000000 / `CVSC_SLOW_RATE_UV_PER_US)
`define CVSC_SLOW_STEP_CYCLES ((`CVSC_SLOW_STEP_PS + `CVSC_CLK_PERIOD_PS - 64'd1) / `CVSC_CLK_PERIOD_PS)

`endif

// ==== logic/cvsc_pkg.sv ====
// Purpose: types of the core scaling control
// Assumes: nothing
// Notes: constants live in cvsc_map.svh
package cvsc_pkg;

   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cvsc_reg_req_t;

   typedef enum logic [1:0] {
      CVSC_IDLE = 2'b00,
      CVSC_RAMP = 2'b01,
      CVSC_DONE = 2'b11
   } cvsc_state_t;

   typedef struct packed {
      logic [10:0] core_mv;
      logic [11:0] linear_one_mv;
      logic [11:0] linear_two_mv;
   } cvsc_levels_t;

endpackage : cvsc_pkg

// ==== logic/cvsc_ramp_timer.sv ====
// Purpose: paces the core ramp, one tick per 25 mV step
// Assumes: run held high for the whole ramp
// Notes: interval halves with each ramp select code
`timescale 1ns/1ps
module cvsc_ramp_timer #(
   parameter int SLOW_STEP_CYCLES = 33334,
   parameter int CW = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [2:0] ramp_sel,
   output logic tick
);
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;

   // rate doubles per code, so the step time halves, rounded up
   function automatic logic [CW-1:0] step_cycles(input logic [2:0] sel);
      int unsigned div;
      int unsigned v;
      div = 32'd1 << sel;
      v = (SLOW_STEP_CYCLES + div - 1) / div;
      if (v < 1) v = 1;
      return v[CW-1:0];
   endfunction : step_cycles

   always_comb begin
      tick = run && (count == step_cycles(ramp_sel) - 1'b1); // R16
      if (!run || tick) begin
         next_count = '0;
      end else begin
         next_count = count + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end
endmodule : cvsc_ramp_timer

// ==== logic/cvsc_code_decode.sv ====
// Purpose: turns voltage codes into millivolt figures
// Assumes: codes come from registers
// Notes: outputs registered
`timescale 1ns/1ps
`include "cvsc_map.svh"
module cvsc_code_decode (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [4:0] core_code,
   input wire logic [2:0] linear_one_sel,
   input wire logic [2:0] linear_two_sel,
   output cvsc_pkg::cvsc_levels_t levels
);
   cvsc_pkg::cvsc_levels_t next_levels;

   function automatic logic [11:0] linear_mv(input logic [2:0] sel);
      case (sel)
         3'h0: linear_mv = 12'h3E8;
         3'h1: linear_mv = 12'h41A;
         3'h2: linear_mv = 12'h44C;
         3'h3: linear_mv = 12'h514;
         3'h4: linear_mv = 12'h708;
         3'h5: linear_mv = 12'h9C4;
         3'h6: linear_mv = 12'hBB8;
         default: linear_mv = 12'hCE4;
      endcase
   endfunction : linear_mv

   always_comb begin
      // top code skips to 1.6 V
      if (core_code == 5'h1F) begin
         next_levels.core_mv = `CVSC_CORE_TOP_MV; // R10
      end else begin
         next_levels.core_mv = `CVSC_CORE_BASE_MV + 11'(core_code * `CVSC_CORE_STEP_MV); // R10
      end
      next_levels.linear_one_mv = linear_mv(linear_one_sel); // R14
      next_levels.linear_two_mv = linear_mv(linear_two_sel); // R14
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         levels <= '0;
      end else begin
         levels <= next_levels;
      end
   end
endmodule : cvsc_code_decode

// ==== verif/cvsc_host_model.sv ====
// Purpose: host side of the register port
// Assumes: requests launched on the falling edge
// Notes: released address and data lines show inverted values
`timescale 1ns/1ps
module cvsc_host_model (
   input wire logic ref_clk,
   output cvsc_pkg::cvsc_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata
);
   initial reg_req = '0;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge ref_clk);
      reg_req = '{w, !w, a, d};
      @(negedge ref_clk);
      reg_req = '{1'b0, 1'b0, ~a, ~d};
      q = reg_rdata;
   endtask : xfer
endmodule : cvsc_host_model

// ==== verif/cvsc_core_properties.sv ====
// Purpose: port checks of the core scaling control
// Assumes: bound to cvsc_core
// Notes: age skips the strap load edge after reset
`timescale 1ns/1ps
module cvsc_core_checker (
   input wire logic ref_clk,
   input wire logic resetn,
   input cvsc_pkg::cvsc_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic core_strap_pin,
   input wire logic system_converter_enabled,
   input wire logic core_converter_enabled,
   input wire logic warm_reset_pin_n,
   input wire logic power_on_reset_out,
   input wire logic rtc_supply_low,
   input wire logic core_rail_below_target,
   input wire logic forced_fixed_freq_sys,
   input wire logic forced_fixed_freq_core,
   input wire logic [2:0] discharge_en,
   input wire logic core_ref_from_strap,
   input wire logic [4:0] core_code,
   input wire logic ramp_busy,
   input wire logic core_rail_not_good
);
   logic [1:0] age;
   logic [1:0] next_age;
   logic rel;
   logic wr4;
   logic wr5;
   assign rel = !warm_reset_pin_n || power_on_reset_out || rtc_supply_low ||
      (!system_converter_enabled && !core_converter_enabled);
   assign wr4 = reg_req.wr_en && reg_req.addr == 8'h04;
   assign wr5 = reg_req.wr_en && reg_req.addr == 8'h05;
   always_comb begin
      next_age = (age == 2'h3) ? age : age + 2'h1;
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         age <= 2'h0;
      end else begin
         age <= next_age;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_fff_sys_mode: assert property (
      wr4 |=> forced_fixed_freq_sys == $past(reg_req.wdata[1])) else $error("system mode bit wrong");
   a_fff_core_mode: assert property (
      wr4 |=> forced_fixed_freq_core == $past(reg_req.wdata[0])) else $error("core mode bit wrong");
   a_discharge_bits: assert property (
      wr5 |=> discharge_en == $past(reg_req.wdata[2:0])) else $error("discharge enables wrong");
   a_strap_source: assert property (
      wr5 |=> core_ref_from_strap == $past(reg_req.wdata[6])) else $error("voltage source bit wrong");
   a_code_held: assert property (
      age != 2'h0 && !ramp_busy && !rel |=> $stable(core_code))
      else $error("core code moved while idle");
   a_reload_code: assert property (
      rel |=> core_code == {1'b1, $past(core_strap_pin), 1'b1, $past(core_strap_pin), 1'b0})
      else $error("core code not reloaded");
   a_resv_zero: assert property (
      reg_req.rd_en && reg_req.addr == 8'h07 |=> reg_rdata[7:3] == 5'h00) else $error("reserved bits set");
   a_rail_flag: assert property (
      age != 2'h0 |-> core_rail_not_good ==
      $past(core_rail_below_target && core_converter_enabled && !ramp_busy)) else $error("rail flag wrong");
   a_rail_quiet: assert property (
      ramp_busy || !core_converter_enabled |=> !core_rail_not_good) else $error("rail flag set while busy");
endmodule : cvsc_core_checker
bind cvsc_core cvsc_core_checker u_chk (.ref_clk, .resetn, .reg_req, .reg_rdata, .core_strap_pin,
   .system_converter_enabled, .core_converter_enabled, .warm_reset_pin_n, .power_on_reset_out,
   .rtc_supply_low, .core_rail_below_target, .forced_fixed_freq_sys, .forced_fixed_freq_core,
   .discharge_en, .core_ref_from_strap, .core_code, .ramp_busy, .core_rail_not_good);

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench of the core scaling control
// Assumes: step count shortened to 64 cycles
// Notes: register model in m, writable bits in msk
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic core_strap_pin = 1'b1;
   logic system_converter_enabled = 1'b1;
   logic core_converter_enabled = 1'b1;
   logic warm_reset_pin_n = 1'b1;
   logic power_on_reset_out = 1'b0;
   logic rtc_supply_low = 1'b0;
   logic core_rail_below_target = 1'b1;
   logic forced_fixed_freq_mem, forced_fixed_freq_sys, forced_fixed_freq_core, core_ref_from_strap;
   logic ramp_busy, core_rail_not_good;
   logic [2:0] discharge_en;
   logic [4:0] core_code;
   logic [7:0] reg_rdata;
   logic [31:0] lf = 32'hAA7B;
   cvsc_pkg::cvsc_reg_req_t reg_req;
   cvsc_pkg::cvsc_levels_t levels;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;
   int m [16];
   int msk [16] = '{4: 8'hFF, 5: 8'hC7, 6: 8'h1F, 7: 8'h07, 8: 8'h77, default: 0};
   logic [11:0] ldo [8] = '{12'h3E8, 12'h41A, 12'h44C, 12'h514, 12'h708, 12'h9C4, 12'hBB8, 12'hCE4};
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   cvsc_host_model host (.ref_clk, .reg_req, .reg_rdata);
   cvsc_core #(.SLOW_STEP_CYCLES(64)) dut (.ref_clk, .resetn, .reg_req, .reg_rdata, .core_strap_pin,
      .system_converter_enabled, .core_converter_enabled, .warm_reset_pin_n, .power_on_reset_out,
      .rtc_supply_low, .core_rail_below_target, .forced_fixed_freq_mem, .forced_fixed_freq_sys,
      .forced_fixed_freq_core, .discharge_en, .core_ref_from_strap, .core_code, .ramp_busy,
      .core_rail_not_good, .levels);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.xfer(1'b1, a, d, q);
      m[a[3:0]] = d & msk[a[3:0]];
   endtask : wr
   task automatic rdc(input logic [7:0] a);
      logic [7:0] q;
      host.xfer(1'b0, a, 8'h00, q);
      check("rdata", q, m[a[3:0]]);
   endtask : rdc
   initial begin
      logic [7:0] q;
      int tgt, cur, st, el, t0, k;
      m = '{4: 8'hB0, 5: 8'h40, 6: 8'h1E, 7: 8'h06, 8: 8'h23, default: 0};
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      resetn = 1'b1;
      for (int a = 4; a < 10; a++) rdc(a[7:0]);
      check("code", core_code, 5'h1E);
      wr(8'h09, 8'hFF);
      rdc(8'h09);
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         wr(8'h04, lf[7:0]);
         check("fff_sys", forced_fixed_freq_sys, lf[1]);
         check("fff_core", forced_fixed_freq_core, lf[0]);
         check("fff_mem", forced_fixed_freq_mem, lf[2]);
         rdc(8'h04);
      end
      wr(8'h05, 8'h3F);
      check("discharge", discharge_en, 3'h7);
      check("source", core_ref_from_strap, 1'b0);
      rdc(8'h05);
      wr(8'h05, 8'h45);
      check("discharge", discharge_en, 3'h5);
      check("source", core_ref_from_strap, 1'b1);
      wr(8'h07, 8'hFF);
      rdc(8'h07);
      for (int i = 0; i < 8; i++) begin
         wr(8'h08, {1'b0, i[2:0], 1'b0, ~i[2:0]});
         @(negedge ref_clk);
         check("linear_one", levels.linear_one_mv, ldo[7 - i]);
         check("linear_two", levels.linear_two_mv, ldo[i]);
      end
      $display("register test done");
      cur = core_code;
      lf = lfsr(lf);
      wr(8'h06, {3'h0, lf[4:0]});
      repeat (10) @(negedge ref_clk);
      check("code", core_code, cur);
      rdc(8'h06);
      for (int s = 0; s < 8; s++) begin
         lf = lfsr(lf);
         tgt = lf[4:0];
         cur = core_code;
         st = (s == 7) ? 0 : (64 + (1 << s) - 1) >> s;
         wr(8'h07, s[7:0]);
         wr(8'h06, tgt[7:0]);
         t0 = cyc;
         wr(8'h05, 8'h80);
         @(negedge ref_clk);
         check("busy", ramp_busy, 1'b1);
         check("not_good", core_rail_not_good, 1'b0);
         q = 8'h80;
         for (k = 0; k < 1500 && q[7]; k++) host.xfer(1'b0, 8'h05, 8'h00, q);
         if (q[7]) begin
            n_mismatch++;
            final_report();
         end
         el = cyc - t0;
         k = (tgt > cur ? tgt - cur : cur - tgt) * st;
         check("code", core_code, tgt);
         check("ramp_time", el >= k && el <= k + 14, 1'b1);
         m[5] = 0;
         rdc(8'h05);
         check("busy", ramp_busy, 1'b0);
         repeat (3) @(negedge ref_clk);
         check("core_mv", levels.core_mv, tgt == 31 ? 11'h640 : 11'h320 + 11'h019 * tgt);
         check("not_good", core_rail_not_good, 1'b1);
      end
      $display("ramp test done");
      for (int e = 0; e < 4; e++) begin
         wr(8'h07, 8'h07);
         wr(8'h06, 8'h05);
         wr(8'h05, 8'h80);
         repeat (4) @(negedge ref_clk);
         check("code", core_code, 5'h05);
         warm_reset_pin_n = (e != 0);
         power_on_reset_out = (e == 1);
         rtc_supply_low = (e == 2);
         system_converter_enabled = (e != 3);
         core_converter_enabled = (e != 3);
         repeat (3) @(negedge ref_clk);
         {warm_reset_pin_n, power_on_reset_out, rtc_supply_low} = 3'h4;
         {system_converter_enabled, core_converter_enabled} = 2'h3;
         check("code", core_code, 5'h1E);
         m[6] = 8'h1E;
         rdc(8'h06);
      end
      $display("reload test done");
      core_strap_pin = 1'b0;
      resetn = 1'b0;
      repeat (3) @(negedge ref_clk);
      resetn = 1'b1;
      @(negedge ref_clk);
      check("code", core_code, 5'h14);
      m = '{4: 8'hB0, 5: 8'h40, 6: 8'h14, 7: 8'h06, 8: 8'h23, default: 0};
      for (int a = 5; a < 8; a++) rdc(a[7:0]);
      $display("strap test done");
      final_report();
   end
endmodule : tb_top
